// >>> include/distributed_time_unit_pkg.sv
package distributed_time_unit_pkg;
	// ------------------------------------------------------------
	// timing and widths
	// ------------------------------------------------------------
	localparam int TIME_W = 64;
	localparam int CLK_PERIOD_NS = 10;
	localparam int STEP_NS = 10;
	localparam logic [7:0] STEP_CYCLES = 8'(STEP_NS / CLK_PERIOD_NS);
	localparam logic [7:0] SLEW_DIV = 8'h10;
	localparam logic [63:0] TIME_RESET = 64'h0;
	// ------------------------------------------------------------
	// configuration memory layout
	// ------------------------------------------------------------
	localparam logic [3:0] CFG_ADDR_ROLE = 4'h0;
	localparam logic [3:0] CFG_ADDR_LAST = 4'h8;
	localparam int CFG_BIT_CAPABLE = 0;
	localparam int CFG_BIT_REFERENCE = 1;
	localparam logic [2:0] FIELD_LAST = 3'h7;
	typedef enum logic [1:0] {
		load_request = 2'b00,
		load_wait = 2'b01,
		load_done = 2'b10
	} load_state_type;
	// one frame byte with tags from the frame parser
	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic [7:0] data;
		logic time_field;
		logic [2:0] field_idx;
		logic meas_hit;
		logic dir;
	} frame_byte_type;
	typedef struct packed {
		logic valid;
		logic [63:0] value;
	} offset_write_type;
endpackage : distributed_time_unit_pkg

// >>> src/distributed_clock_sync.sv
`timescale 1ns/1ps
module distributed_clock_sync
	import distributed_time_unit_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire frame_byte_type rx_byte,
	output frame_byte_type tx_byte,
	input wire offset_write_type offset_wr,
	output logic cfg_rd,
	output logic [3:0] cfg_addr,
	input wire logic cfg_ack,
	input wire logic [7:0] cfg_rdata,
	output logic cfg_loaded,
	output logic is_reference,
	output logic [63:0] local_time,
	output logic [63:0] system_time,
	output logic [63:0] meas_time_fwd,
	output logic [63:0] meas_time_ret
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	load_state_type load_q;
	logic [3:0] addr_q;
	logic capable_q;
	logic reference_q;
	logic [63:0] offset_q;
	logic [63:0] time_q;
	logic [63:0] sys_q;
	logic [63:0] snap_q;
	logic [55:0] rx_time_q;
	logic signed [63:0] err_q;
	logic [7:0] slew_cnt_q;
	logic slew_tick_q;
	logic cfg_rd_q;
	logic cfg_loaded_q;
	logic [63:0] sys_now;
	logic [63:0] ref_time;
	logic follower;
	logic adj_up;
	logic adj_dn;
	frame_byte_type tx_q;
	logic [63:0] meas_q [2];

	assign sys_now = time_q + offset_q;
	assign follower = capable_q && !reference_q && (load_q == load_done);
	assign ref_time = {rx_byte.data, rx_time_q};
	assign adj_up = slew_tick_q && (err_q > 0);
	assign adj_dn = slew_tick_q && (err_q < 0);

	// ------------------------------------------------------------
	// configuration load
	// ------------------------------------------------------------
	// fetch role byte then eight offset bytes, one request at a time
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			load_q <= load_request;
			addr_q <= CFG_ADDR_ROLE;
			cfg_rd_q <= 1'b0;
			cfg_loaded_q <= 1'b0;
		end else begin
			// request and done flags flopped beside the state so the pins come from flip-flops
			case (load_q)
				load_request: begin
					load_q <= load_wait;
					cfg_rd_q <= 1'b1;
				end
				load_wait: begin
					if (cfg_ack) begin
						cfg_rd_q <= 1'b0;
						if (addr_q == CFG_ADDR_LAST) begin
							load_q <= load_done;
							cfg_loaded_q <= 1'b1;
						end else begin
							addr_q <= addr_q + 4'h1;
							load_q <= load_request;
						end
					end
				end
				load_done: begin
					load_q <= load_done;
				end
				default: begin
					load_q <= load_request;
					cfg_rd_q <= 1'b0;
					cfg_loaded_q <= 1'b0;
				end
			endcase
		end
	end

	// role flags and offset come from the memory, master writes override offset except in a cycle where the memory acknowledges a byte
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			capable_q <= 1'b0;
			reference_q <= 1'b0;
			offset_q <= TIME_RESET;
		end else if (load_q == load_wait && cfg_ack) begin
			if (addr_q == CFG_ADDR_ROLE) begin
				capable_q <= cfg_rdata[CFG_BIT_CAPABLE];
				reference_q <= cfg_rdata[CFG_BIT_REFERENCE];
			end else begin
				offset_q[(addr_q - 4'h1) * 8 +: 8] <= cfg_rdata;
			end
		end else if (offset_wr.valid) begin
			offset_q <= offset_wr.value;
		end
	end

	// ------------------------------------------------------------
	// local time counter
	// ------------------------------------------------------------
	// free running from reset, ten per cycle, units digit used for slewing
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			time_q <= TIME_RESET;
		end else if (adj_up) begin
			time_q <= time_q + 64'(STEP_NS) + 64'h1;
		end else if (adj_dn) begin
			time_q <= time_q + 64'(STEP_NS) - 64'h1;
		end else begin
			time_q <= time_q + 64'(STEP_NS);
		end
	end

	// slew enable divider limits correction to one ns per sixteen clock periods
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			slew_cnt_q <= 8'h0;
			slew_tick_q <= 1'b0;
		end else begin
			slew_tick_q <= (slew_cnt_q == SLEW_DIV - 8'h1);
			slew_cnt_q <= (slew_cnt_q == SLEW_DIV - 8'h1) ? 8'h0 : slew_cnt_q + 8'h1;
		end
	end

	// system time register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sys_q <= TIME_RESET;
		end else begin
			sys_q <= sys_now;
		end
	end

	// ------------------------------------------------------------
	// follower capture and error
	// ------------------------------------------------------------
	// collect reference time bytes, then hold the error to be slewed away
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_time_q <= 56'h0;
			err_q <= 64'sh0;
		end else if (follower && rx_byte.valid && rx_byte.time_field) begin
			if (rx_byte.field_idx == FIELD_LAST) begin
				err_q <= $signed(ref_time - sys_now);
			end else begin
				rx_time_q[rx_byte.field_idx * 8 +: 8] <= rx_byte.data;
			end
		end else if (adj_up) begin
			err_q <= err_q - 64'sh1;
		end else if (adj_dn) begin
			err_q <= err_q + 64'sh1;
		end
	end

	// ------------------------------------------------------------
	// on-the-fly forwarding with time insertion
	// ------------------------------------------------------------
	// snapshot at first time byte so all eight bytes belong to one instant
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			snap_q <= TIME_RESET;
		end else if (rx_byte.valid && rx_byte.time_field && rx_byte.field_idx == 3'h0) begin
			snap_q <= sys_now;
		end
	end

	// one register stage per byte, no frame storage
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_q <= '0;
		end else begin
			tx_q <= rx_byte;
			if (reference_q && capable_q && rx_byte.valid && rx_byte.time_field) begin
				if (rx_byte.field_idx == 3'h0) begin
					tx_q.data <= sys_now[7:0];
				end else begin
					tx_q.data <= snap_q[rx_byte.field_idx * 8 +: 8];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// measurement latches
	// ------------------------------------------------------------
	// one latch per traversal direction
	generate
		for (genvar d = 0; d < 2; d++) begin : g_meas
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					meas_q[d] <= TIME_RESET;
				end else if (rx_byte.valid && rx_byte.meas_hit && rx_byte.dir == 1'(d)) begin
					meas_q[d] <= sys_now;
				end
			end
		end
	endgenerate

	// outputs
	assign tx_byte = tx_q;
	assign cfg_rd = cfg_rd_q;
	assign cfg_addr = addr_q;
	assign cfg_loaded = cfg_loaded_q;
	assign is_reference = reference_q;
	assign local_time = time_q;
	assign system_time = sys_q;
	assign meas_time_fwd = meas_q[0];
	assign meas_time_ret = meas_q[1];

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_last_time_byte;
		follower && rx_byte.valid && rx_byte.time_field && rx_byte.field_idx == FIELD_LAST;
	endsequence

	a_time_always_runs: assert property ($past(rstn) |-> (time_q - $past(time_q)) inside {64'd9, 64'd10, 64'd11})
		else $error("local time did not advance by one step");
	// offset writes and configuration bytes reach the system time two edges later
	a_no_time_step: assert property ($past(rstn) && $past(cfg_loaded, 2) && !$past(offset_wr.valid, 2)
		|-> (sys_q - $past(sys_q)) inside {64'h9, 64'hA, 64'hB})
		else $error("system time stepped");
	a_plain_step_idle: assert property ($past(rstn) && !slew_tick_q |=> time_q == $past(time_q) + 64'hA)
		else $error("step without slew was not ten");
	a_meas_fwd_latch: assert property (rx_byte.valid && rx_byte.meas_hit && !rx_byte.dir |=> meas_time_fwd == $past(sys_now))
		else $error("forward arrival time not latched");
	a_meas_ret_latch: assert property (rx_byte.valid && rx_byte.meas_hit && rx_byte.dir |=> meas_time_ret == $past(sys_now))
		else $error("return arrival time not latched");
	a_forward_one_cycle: assert property (tx_byte.valid == $past(rx_byte.valid) && tx_byte.last == $past(rx_byte.last))
		else $error("frame byte not forwarded after one cycle");
	a_ref_insert_byte: assert property (reference_q && capable_q && rx_byte.valid && rx_byte.time_field
		&& rx_byte.field_idx == 3'h0 |=> tx_byte.data == $past(sys_now[7:0]) ##1 1'b1)
		else $error("reference time not inserted");
	a_follow_error: assert property (s_last_time_byte |=> err_q == $signed($past(ref_time) - $past(sys_now)))
		else $error("follower error not captured");
	a_slew_direction: assert property (slew_tick_q && err_q > 0 |=> time_q == $past(time_q) + 64'hB)
		else $error("slew did not speed clock");
	a_sys_offset: assert property (system_time == $past(local_time) + $past(offset_q))
		else $error("system time is not local plus offset");
	a_load_sequence: assert property (cfg_rd && cfg_ack && cfg_addr == CFG_ADDR_LAST |=> cfg_loaded)
		else $error("configuration load did not finish");
endmodule : distributed_clock_sync

// >>> bench/cfg_memory_model.sv
`timescale 1ns/1ps
// nonvolatile configuration memory answering byte reads after a chosen wait
module cfg_memory_model (
	input wire logic clock,
	input wire logic rstn,
	input wire logic cfg_rd,
	input wire logic [3:0] cfg_addr,
	input wire logic [71:0] image,
	input wire logic [3:0] wait_cycles,
	output logic cfg_ack,
	output logic [7:0] cfg_rdata
);
	logic [3:0] cnt_q;
	// one answer per request; data is scrambled whenever no answer stands
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 4'h0;
			cfg_ack <= 1'b0;
			cfg_rdata <= 8'hA5;
		end else if (cfg_rd && !cfg_ack && cnt_q >= wait_cycles) begin
			cnt_q <= 4'h0;
			cfg_ack <= 1'b1;
			cfg_rdata <= image[{cfg_addr, 3'b000} +: 8];
		end else begin
			cnt_q <= (cfg_rd && !cfg_ack) ? cnt_q + 4'h1 : 4'h0;
			cfg_ack <= 1'b0;
			cfg_rdata <= ~cfg_rdata;
		end
	end
endmodule : cfg_memory_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import distributed_time_unit_pkg::*;
	logic clock, rstn, cfg_rd, cfg_ack, cfg_loaded, is_reference, ref_m, live, on, pf, pr;
	logic [3:0] cfg_addr, wait_cycles;
	logic [7:0] cfg_rdata;
	logic [71:0] image;
	logic [63:0] local_time, system_time, meas_time_fwd, meas_time_ret;
	logic [63:0] off_m, cfg_off, exp_sys, snap, exp_mf, exp_mr, last_lt;
	frame_byte_type rx_byte, tx_byte, exp_tx;
	offset_write_type offset_wr;
	int fail_count, comparisons, cycles, seed;
	distributed_clock_sync dut_u (.clock(clock), .rstn(rstn), .rx_byte(rx_byte), .tx_byte(tx_byte),
		.offset_wr(offset_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.cfg_loaded(cfg_loaded), .is_reference(is_reference), .local_time(local_time),
		.system_time(system_time), .meas_time_fwd(meas_time_fwd), .meas_time_ret(meas_time_ret));
	cfg_memory_model mem_u (.clock(clock), .rstn(rstn), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .image(image),
		.wait_cycles(wait_cycles), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic give_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	task automatic send(input logic [7:0] d, input logic tf, input logic [2:0] idx, input logic mh, input logic dr);
		rx_byte <= '{1'b1, idx == 3'h0, idx == 3'h7, d, tf, idx, mh, dr};
		@(posedge clock);
	endtask : send
	task automatic restart(input logic [7:0] role, input logic [3:0] w);
		logic [63:0] off;
		off = {$random(seed), $random(seed)};
		rstn <= 1'b0;
		rx_byte <= '0;
		ref_m <= role[1];
		cfg_off <= off;
		image <= {off, role};
		wait_cycles <= w;
		repeat (10) @(posedge clock);
		check("reset_time", 64'h0, local_time);
		rstn <= 1'b1;
		@(posedge clock);
		#1 check("first_step", 64'hA, local_time);
		for (int i = 0; i < 100 && !cfg_loaded; i++)
			@(posedge clock);
		check("cfg_loaded", 64'h1, 64'(cfg_loaded));
		check("is_reference", 64'(role[1]), 64'(is_reference));
	endtask : restart
	// follower gets a time datagram off by e ns and must absorb it by slewing only
	task automatic follow(input int e);
		logic [63:0] t, l0;
		l0 = local_time;
		t = local_time + 64'h50 + cfg_off + 64'(e);
		for (int i = 0; i < 8; i++)
			send(t[i*8 +: 8], 1'b1, 3'(i), 1'b0, 1'b0);
		rx_byte <= '0;
		repeat (292) @(posedge clock);
		check("slewed_time", l0 + 64'd3000 + 64'(e), local_time);
	endtask : follow
	// ------------------------------------------------------------
	// clock, timeout and output model
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// cuts a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			give_verdict();
		end
	end
	// compares tx_byte and time step at each edge, system time once loaded and measurement latches after each hit, with the bench model
	always @(posedge clock) begin
		// no comparisons while reset is applied
		if (live && rstn) begin
			check("tx_byte", 64'(exp_tx), 64'(tx_byte));
			check("time_step", 64'h1, 64'((local_time - last_lt == 10) || (!ref_m && local_time - last_lt inside {9, 11})));
		end
		if (on && rstn) begin
			check("system_time", exp_sys, system_time);
			if (pf)
				check("meas_fwd", exp_mf, meas_time_fwd);
			if (pr)
				check("meas_ret", exp_mr, meas_time_ret);
		end
		if (cfg_loaded && !on)
			off_m = cfg_off;
		exp_sys = local_time + off_m;
		pf = rx_byte.valid && rx_byte.meas_hit && !rx_byte.dir;
		pr = rx_byte.valid && rx_byte.meas_hit && rx_byte.dir;
		exp_mf = pf ? exp_sys : exp_mf;
		exp_mr = pr ? exp_sys : exp_mr;
		if (rx_byte.valid && rx_byte.time_field && rx_byte.field_idx == 3'h0)
			snap = exp_sys;
		exp_tx = rx_byte;
		if (ref_m && cfg_loaded && rx_byte.valid && rx_byte.time_field)
			exp_tx.data = snap[{rx_byte.field_idx, 3'b000} +: 8];
		if (offset_wr.valid)
			off_m = offset_wr.value;
		on = rstn && cfg_loaded;
		live = rstn;
		last_lt = local_time;
	end
	// reference phase, then a second reset into follower phase
	initial begin
		seed = 85;
		{fail_count, comparisons, cycles} = '0;
		{live, on, pf, pr, ref_m} = '0;
		{off_m, cfg_off, exp_sys, snap, exp_mf, exp_mr, last_lt} = '0;
		rstn = 1'b0;
		rx_byte = '0;
		offset_wr = '0;
		image = '0;
		wait_cycles = 4'h0;
		@(posedge clock);
		restart(8'h03, 4'h0);
		for (int i = 0; i < 40; i++)
			send(8'($random(seed)), 1'b0, 3'h0, 1'b0, 1'b0);
		offset_wr <= '{1'b1, {$random(seed), $random(seed)}};
		@(posedge clock);
		offset_wr <= '0;
		for (int i = 0; i < 8; i++)
			send(8'($random(seed)), 1'b1, 3'(i), 1'b0, 1'b0);
		// measurement broadcast repeated in both directions, latches read back each time
		for (int i = 0; i < 3; i++) begin
			send(8'h00, 1'b0, 3'h0, 1'b1, 1'b0);
			send(8'h00, 1'b0, 3'h0, 1'b1, 1'b1);
		end
		rx_byte <= '0;
		repeat (20) @(posedge clock);
		restart(8'h01, 4'h3);
		follow(5);
		follow(-3);
		give_verdict();
	end
endmodule : tb_top
